// ===== rtl/tls_pkg.sv
// Constants and types for the torque limit selector
// Notes on behaviour
// - Forward select low: min of internal, external forward; ignored with option value 1 in speed or position mode
// - Reverse select low: min of internal, external reverse; ignored with option value 1 in speed or position mode
// - Select high: internal limit for that direction, capped by the analog limit when it is on
// - Single axis uses inputs seven, eight; dual allocated
// - Functions sharing one terminal follow its OR'd state
// - Analog limit magnitude applies to both directions
// - Analog limit only in speed or position mode
// - Option value 1: analog terminal is torque limit
// - Option value 2: feed-forward, never a limit
// - Option value 3: selects plus analog limit
// - Combined mode: min of internal, analog and external limit
// - Analog input scaled by configurable input gain
`default_nettype none
package tls_pkg;
    localparam int unsigned LIM_W      = 9;
    localparam int unsigned ANA_W      = 12;
    localparam int unsigned GAIN_W     = 8;
    localparam int unsigned TRQ_W      = 12;
    localparam int unsigned TERM_W     = 8;
    localparam logic [8:0]  LIM_MAX    = 9'h12c;
    localparam logic [8:0]  INT_RST    = 9'h12c;
    localparam logic [8:0]  EXT_RST    = 9'h064;
    localparam logic [2:0]  FWD_TERM_SINGLE = 3'h6;
    localparam logic [2:0]  REV_TERM_SINGLE = 3'h7;
    localparam logic [1:0]  OPT_NONE   = 2'h0;
    localparam logic [1:0]  OPT_ALIM   = 2'h1;
    localparam logic [1:0]  OPT_FFWD   = 2'h2;
    localparam logic [1:0]  OPT_BOTH   = 2'h3;
    localparam int unsigned GAIN_SHIFT = 5;

    typedef enum logic [2:0] {
        TLS_MODE_SPEED    = 3'b001,
        TLS_MODE_POSITION = 3'b010,
        TLS_MODE_TORQUE   = 3'b100
    } tls_mode_t;

    typedef struct packed {
        logic [8:0] internal_fwd_limit;
        logic [8:0] internal_rev_limit;
        logic [8:0] external_fwd_limit;
        logic [8:0] external_rev_limit;
    } tls_params_t;

    typedef struct packed {
        logic [8:0] fwd;
        logic [8:0] rev;
    } tls_limits_t;
endpackage : tls_pkg
`default_nettype wire

// ===== rtl/tls_selector.sv
// Torque limit selector: picks per-direction limit and clamps torque command
`default_nettype none
module tls_selector (
    input  wire logic                        clk_sys_in,
    input  wire logic                        resetn_in,
    input  wire logic [7:0]                  general_inputs_n_in,
    input  wire logic                        dual_axis_in,
    input  wire logic [2:0]                  fwd_alloc_in,
    input  wire logic [2:0]                  rev_alloc_in,
    input  wire logic                        params_we_in,
    input  wire tls_pkg::tls_params_t        params_in,
    input  wire logic [1:0]                  speed_option_in,
    input  wire tls_pkg::tls_mode_t          ctrl_mode_in,
    input  wire logic signed [11:0]          analog_limit_in,
    input  wire logic [7:0]                  torque_gain_in,
    input  wire logic signed [11:0]          torque_cmd_in,
    output var  tls_pkg::tls_limits_t        limits_out,
    output var  logic signed [11:0]          torque_clamped_out,
    output var  logic                        fwd_limit_select_out,
    output var  logic                        rev_limit_select_out,
    output var  logic                        feedfwd_enable_out
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    logic [7:0]                   gin_meta_q;
    logic [7:0]                   gin_sync_q;
    logic signed [11:0]           ana_meta_q;
    logic signed [11:0]           ana_sync_q;
    logic signed [11:0]           ana_prev_q;
    logic signed [11:0]           ana_hold_q;
    tls_pkg::tls_params_t         params_q;

    // Bits of the converted word may settle on different edges: a value is
    // taken only once it reads the same on two edges, else the last one holds
    wire signed [11:0] ana_val = (ana_sync_q == ana_prev_q) ? ana_sync_q : ana_hold_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            gin_meta_q <= 8'hff;
            gin_sync_q <= 8'hff;
            ana_meta_q <= 12'h000;
            ana_sync_q <= 12'h000;
            ana_prev_q <= 12'h000;
            ana_hold_q <= 12'h000;
        end else begin
            gin_meta_q <= general_inputs_n_in;
            gin_sync_q <= gin_meta_q;
            ana_meta_q <= analog_limit_in;
            ana_sync_q <= ana_meta_q;
            ana_prev_q <= ana_sync_q;
            ana_hold_q <= ana_val;
        end
    end

    function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
        min9 = (a < b) ? a : b;
    endfunction

    function automatic logic [8:0] sat9(input logic [8:0] v);
        sat9 = (v > tls_pkg::LIM_MAX) ? tls_pkg::LIM_MAX : v;
    endfunction

    // ****************************************
    // Parameters, live update without restart
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            params_q.internal_fwd_limit <= tls_pkg::INT_RST;
            params_q.internal_rev_limit <= tls_pkg::INT_RST;
            params_q.external_fwd_limit <= tls_pkg::EXT_RST;
            params_q.external_rev_limit <= tls_pkg::EXT_RST;
        end else if (params_we_in) begin
            params_q.internal_fwd_limit <= sat9(params_in.internal_fwd_limit);
            params_q.internal_rev_limit <= sat9(params_in.internal_rev_limit);
            params_q.external_fwd_limit <= sat9(params_in.external_fwd_limit);
            params_q.external_rev_limit <= sat9(params_in.external_rev_limit);
        end
    end

    // ****************************************
    // Terminal allocation
    // ****************************************
    // A terminal is one wire: every function mapped to it sees the same level
    wire [2:0] fwd_term = dual_axis_in ? fwd_alloc_in : tls_pkg::FWD_TERM_SINGLE;
    wire [2:0] rev_term = dual_axis_in ? rev_alloc_in : tls_pkg::REV_TERM_SINGLE;
    wire fwd_limit_sel_n = gin_sync_q[fwd_term];
    wire rev_limit_sel_n = gin_sync_q[rev_term];

    // ****************************************
    // Option decode
    // ****************************************
    wire mode_ok   = (ctrl_mode_in == tls_pkg::TLS_MODE_SPEED) ||
                     (ctrl_mode_in == tls_pkg::TLS_MODE_POSITION);
    wire ana_lim   = mode_ok && ((speed_option_in == tls_pkg::OPT_ALIM) ||
                                 (speed_option_in == tls_pkg::OPT_BOTH));
    wire combined  = ana_lim && (speed_option_in == tls_pkg::OPT_BOTH);
    wire feedfwd   = mode_ok && (speed_option_in == tls_pkg::OPT_FFWD);
    wire fwd_on    = !fwd_limit_sel_n;
    wire rev_on    = !rev_limit_sel_n;

    // ****************************************
    // Analog limit: magnitude times gain
    // ****************************************
    wire [11:0] ana_abs = ana_val[11] ? 12'(-ana_val) : 12'(ana_val);
    wire [19:0] ana_prod = {8'h00, ana_abs} * {12'h000, torque_gain_in};
    wire [19:0] ana_scl  = ana_prod >> tls_pkg::GAIN_SHIFT;
    wire [8:0]  ana_pct  = (ana_scl > 20'(tls_pkg::LIM_MAX)) ? tls_pkg::LIM_MAX
                                                             : ana_scl[8:0];

    // ****************************************
    // Limit selection
    // ****************************************
    // Analog is an extra cap on top of the internal limits
    wire [8:0] fwd_base = ana_lim ? min9(params_q.internal_fwd_limit, ana_pct)
                                  : params_q.internal_fwd_limit;
    wire [8:0] rev_base = ana_lim ? min9(params_q.internal_rev_limit, ana_pct)
                                  : params_q.internal_rev_limit;
    // In option 1 in speed or position mode the selects are not active; every other option and mode honours them
    wire sel_ok = !ana_lim || combined;
    wire [8:0] fwd_sel = (sel_ok && fwd_on) ?
                         min9(fwd_base, params_q.external_fwd_limit) : fwd_base;
    wire [8:0] rev_sel = (sel_ok && rev_on) ?
                         min9(rev_base, params_q.external_rev_limit) : rev_base;

    tls_pkg::tls_limits_t lim_d;
    assign lim_d.fwd = fwd_sel;
    assign lim_d.rev = rev_sel;

    // Limit is in percent; torque command is in percent of rated too
    wire signed [11:0] fwd_cap = $signed({3'h0, fwd_sel});
    wire signed [11:0] rev_cap = -$signed({3'h0, rev_sel});
    wire signed [11:0] trq_d = (torque_cmd_in > fwd_cap) ? fwd_cap :
                               (torque_cmd_in < rev_cap) ? rev_cap : torque_cmd_in;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            limits_out           <= '{fwd: tls_pkg::INT_RST, rev: tls_pkg::INT_RST};
            torque_clamped_out   <= 12'sh000;
            fwd_limit_select_out <= 1'b0;
            rev_limit_select_out <= 1'b0;
            feedfwd_enable_out   <= 1'b0;
        end else begin
            limits_out           <= lim_d;
            torque_clamped_out   <= trq_d;
            fwd_limit_select_out <= sel_ok && fwd_on;
            rev_limit_select_out <= sel_ok && rev_on;
            feedfwd_enable_out   <= feedfwd;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    fwd_clamp_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        $signed(torque_clamped_out) <= $signed({3'h0, limits_out.fwd}))
        else $error("forward torque above limit");
    rev_clamp_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        $signed(torque_clamped_out) >= -$signed({3'h0, limits_out.rev}))
        else $error("reverse torque below limit");
    tq_pass_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (torque_cmd_in <= fwd_cap && torque_cmd_in >= rev_cap) |=>
            torque_clamped_out == $past(torque_cmd_in))
        else $error("torque inside limits altered");

    fwd_ext_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!ana_lim && fwd_on) |=> limits_out.fwd ==
            min9($past(params_q.internal_fwd_limit), $past(params_q.external_fwd_limit)))
        else $error("forward external limit wrong");
    rev_ext_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!ana_lim && rev_on) |=> limits_out.rev ==
            min9($past(params_q.internal_rev_limit), $past(params_q.external_rev_limit)))
        else $error("reverse external limit wrong");
    fwd_int_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!ana_lim && !fwd_on) |=> limits_out.fwd == $past(params_q.internal_fwd_limit))
        else $error("forward internal limit wrong");
    rev_int_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!ana_lim && !rev_on) |=> limits_out.rev == $past(params_q.internal_rev_limit))
        else $error("reverse internal limit wrong");

    single_term_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!dual_axis_in && !ana_lim) |=>
            fwd_limit_select_out == !$past(gin_sync_q[tls_pkg::FWD_TERM_SINGLE]) &&
            rev_limit_select_out == !$past(gin_sync_q[tls_pkg::REV_TERM_SINGLE]))
        else $error("single axis terminal wrong");
    shared_term_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (dual_axis_in && fwd_alloc_in == rev_alloc_in) |=>
            fwd_limit_select_out == rev_limit_select_out)
        else $error("shared terminal functions differ");

    torque_mode_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (ctrl_mode_in == tls_pkg::TLS_MODE_TORQUE && !fwd_on) |=>
            !feedfwd_enable_out && limits_out.fwd == $past(params_q.internal_fwd_limit))
        else $error("analog use in torque mode");
    ffwd_excl_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (feedfwd && !rev_on) |=>
            feedfwd_enable_out && limits_out.rev == $past(params_q.internal_rev_limit))
        else $error("feed-forward with analog limit");
    ana_only_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (speed_option_in == tls_pkg::OPT_ALIM &&
            (ctrl_mode_in == tls_pkg::TLS_MODE_SPEED ||
             ctrl_mode_in == tls_pkg::TLS_MODE_POSITION)) |=>
            !fwd_limit_select_out && !rev_limit_select_out)
        else $error("select active in analog-only option");
    both_sel_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (ctrl_mode_in == tls_pkg::TLS_MODE_SPEED && speed_option_in == tls_pkg::OPT_BOTH &&
            fwd_on && rev_on) |=> fwd_limit_select_out && rev_limit_select_out)
        else $error("selects ignored in combined option");
    combined_min_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (combined && fwd_on) |=> limits_out.fwd <= $past(ana_pct) &&
            limits_out.fwd <= $past(params_q.external_fwd_limit))
        else $error("combined forward limit too high");
    comb_rev_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (combined && rev_on) |=> limits_out.rev <= $past(ana_pct) &&
            limits_out.rev <= $past(params_q.external_rev_limit))
        else $error("combined reverse limit too high");

    sym_analog_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (ana_lim && !combined) |=> limits_out.fwd <= $past(ana_pct) &&
            limits_out.rev <= $past(ana_pct))
        else $error("analog limit not applied both ways");
    ana_gain_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (torque_gain_in == 8'(1 << tls_pkg::GAIN_SHIFT) &&
            ana_abs <= 12'(tls_pkg::LIM_MAX)) |-> ana_pct == ana_abs[8:0])
        else $error("unity gain changes analog limit");
    ana_hold_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (ana_sync_q != ana_prev_q) |=> ana_hold_q == $past(ana_hold_q))
        else $error("unsettled analog word taken");
    ext_range_a : assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        params_q.external_fwd_limit <= tls_pkg::LIM_MAX &&
            params_q.external_rev_limit <= tls_pkg::LIM_MAX)
        else $error("external limit out of range");
endmodule : tls_selector
`default_nettype wire

// ===== tb/tls_host_model.sv
// Host controller model driving the active-low limit select terminals
`default_nettype none
module tls_host_model (
    input  wire logic       fwd_on_in,
    input  wire logic       rev_on_in,
    input  wire logic [2:0] fwd_term_in,
    input  wire logic [2:0] rev_term_in,
    output var  logic [7:0] general_inputs_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************
    // Terminal drive
    // ************************************************
    // Released terminals sit at the pull-up level, never at the last value
    always_comb begin
        general_inputs_n_out = 8'hff;
        if (fwd_on_in) general_inputs_n_out[fwd_term_in] = 1'b0;
        if (rev_on_in) general_inputs_n_out[rev_term_in] = 1'b0;
    end
endmodule // tls_host_model
`default_nettype wire

// ===== tb/torque_limit_selector_tb.sv
// Self-checking bench for the torque limit selector
`default_nettype none
module torque_limit_selector_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************
    // Stimulus, checks and report
    // ************************************************
    logic clk_sys_in = 1'b0, resetn_in = 1'b0, dual_axis_in = 1'b0, params_we_in = 1'b0;
    logic fwd_on = 1'b0, rev_on = 1'b0, fsel, rsel, ffwd;
    logic [2:0] term_f = tls_pkg::FWD_TERM_SINGLE, term_r = tls_pkg::REV_TERM_SINGLE;
    logic [7:0] gin_n, torque_gain_in = 8'h20;
    logic [1:0] speed_option_in = tls_pkg::OPT_NONE;
    logic signed [11:0] analog_limit_in = 12'sh000, torque_cmd_in = 12'sh000, tq_out;
    tls_pkg::tls_params_t params_in = '0;
    tls_pkg::tls_mode_t ctrl_mode_in = tls_pkg::TLS_MODE_SPEED;
    tls_pkg::tls_limits_t limits_out;
    int bad_count = 0, n_checks = 0, cyc = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    tls_host_model i_tls_host_model (.fwd_on_in(fwd_on), .rev_on_in(rev_on),
        .fwd_term_in(term_f), .rev_term_in(term_r), .general_inputs_n_out(gin_n));
    tls_selector i_tls_selector (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .general_inputs_n_in(gin_n), .dual_axis_in(dual_axis_in), .fwd_alloc_in(term_f),
        .rev_alloc_in(term_r), .params_we_in(params_we_in), .params_in(params_in),
        .speed_option_in(speed_option_in), .ctrl_mode_in(ctrl_mode_in),
        .analog_limit_in(analog_limit_in), .torque_gain_in(torque_gain_in),
        .torque_cmd_in(torque_cmd_in), .limits_out(limits_out), .torque_clamped_out(tq_out),
        .fwd_limit_select_out(fsel), .rev_limit_select_out(rsel), .feedfwd_enable_out(ffwd));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic look(input logic [8:0] f, r, input logic [1:0] s, input logic ff);
        n_checks++;
        if (limits_out !== {f, r} || {fsel, rsel} !== s || ffwd !== ff) begin
            bad_count++;
            $display("MISMATCH at %0t: limits %h/%h flags %b%b%b", $time, limits_out.fwd,
                     limits_out.rev, fsel, rsel, ffwd);
        end
        $display("test %0d done", n_checks);
    endtask
    task automatic check(input logic [8:0] f, r, input logic [1:0] s, input logic ff);
        step(4);
        look(f, r, s, ff);
    endtask
    task automatic tq(input logic signed [11:0] cmd, exp);
        torque_cmd_in = cmd;
        step(2);
        n_checks++;
        if (tq_out !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: clamped torque %0d", $time, tq_out);
        end
    endtask
    task automatic wp(input logic [8:0] i_f, i_r, e_f, e_r);
        params_in = '{i_f, i_r, e_f, e_r};
        params_we_in = 1'b1;
        step(1);
        params_we_in = 1'b0;
    endtask
    // Ceiling is over fifty times the expected run of about 54 cycles
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc > 3000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        step(3);
        look(9'h12c, 9'h12c, 2'b00, 1'b0);
        resetn_in = 1'b1;
        fwd_on = 1'b1;
        check(9'h064, 9'h12c, 2'b10, 1'b0);
        rev_on = 1'b1;
        check(9'h064, 9'h064, 2'b11, 1'b0);
        wp(9'h0c8, 9'h1ff, 9'h15e, 9'h00a);
        check(9'h0c8, 9'h00a, 2'b11, 1'b0);
        tq(12'sd500, 12'sd200);
        tq(-12'sd500, -12'sd10);
        speed_option_in = tls_pkg::OPT_ALIM;
        analog_limit_in = -12'sd64;
        check(9'h040, 9'h040, 2'b00, 1'b0);
        torque_gain_in = 8'h10;
        check(9'h020, 9'h020, 2'b00, 1'b0);
        speed_option_in = tls_pkg::OPT_BOTH;
        ctrl_mode_in = tls_pkg::TLS_MODE_TORQUE;
        check(9'h0c8, 9'h00a, 2'b11, 1'b0);
        wp(9'h12c, 9'h12c, 9'h032, 9'h12c);
        ctrl_mode_in = tls_pkg::TLS_MODE_POSITION;
        torque_gain_in = 8'h20;
        analog_limit_in = 12'sd80;
        check(9'h032, 9'h050, 2'b11, 1'b0);
        speed_option_in = tls_pkg::OPT_FFWD;
        check(9'h032, 9'h12c, 2'b11, 1'b1);
        speed_option_in = tls_pkg::OPT_NONE;
        rev_on = 1'b0;
        fwd_on = 1'b0;
        check(9'h12c, 9'h12c, 2'b00, 1'b0);
        dual_axis_in = 1'b1;
        term_f = 3'h2;
        term_r = 3'h2;
        fwd_on = 1'b1;
        check(9'h032, 9'h12c, 2'b11, 1'b0);
        resetn_in = 1'b0;
        step(1);
        resetn_in = 1'b1;
        check(9'h064, 9'h064, 2'b11, 1'b0);
        stop_test();
    end
endmodule // torque_limit_selector_tb
`default_nettype wire
